// >>> rtl/cfr_pkg.sv
// Purpose : Constants for the sample and command response framer
// Assumes : One 25 MHz clock, synchronous active-high reset
// Notes   : Offsets are AXI4-Lite byte addresses
//
// Overview of operation
// R1 - Sample frame type byte is 0x83
// R2 - Source short address, high byte first
// R3 - Signal strength as magnitude of dBm
// R4 - Options: bit1 address, bit2 PAN broadcast
// R5 - Sample set count in byte 8
// R6 - Channel mask bytes 9-10, high first
// R7 - Mask: 3 reserved, 4 analog, 9 digital
// R8 - Digital bytes when any line enabled
// R9 - Omit digital bytes when none enabled
// R10 - Each analog: 10 bits right-justified, 16
// R11 - Analog words in ascending channel order
// R12 - Command requests answered with type 0x88
// R13 - Sequence ends with status 0, no data
// R14 - Echo frame id; id zero sends nothing
// R15 - Bytes 5-6 hold command name
// R16 - Status 0 ok,1 error,2 unknown,3 bad
// R17 - Query returns data; write omits it
// R18 - Envelope: delimiter, length, trailing checksum
package cfr_pkg;
    // ************************************************************
    // Frame bytes
    // ************************************************************
    localparam logic [7:0] START_DELIM   = 8'h7E;
    localparam logic [7:0] TYPE_SAMPLE16 = 8'h83;
    localparam logic [7:0] TYPE_CMD_RESP = 8'h88;
    localparam logic [7:0] OPT_KEEP_MASK = 8'h06;
    localparam logic [7:0] CSUM_BASE     = 8'hFF;
    localparam logic [7:0] STATUS_OK     = 8'h00;
    localparam int         FRAME_MAX     = 18;
    localparam int         SMP_FIXED_LEN = 8;
    localparam int         CMD_FIXED_LEN = 5;
    localparam int         CMD_DATA_MAX  = 4;
    localparam int         ANA_CHANNELS  = 4;
    localparam int         MASK_DIG_LSB  = 0;
    localparam int         MASK_ANA_LSB  = 9;
    localparam int         MASK_RES_LSB  = 13;
    localparam int         FIFO_DEPTH    = 32;
    localparam int         FIFO_WIDTH    = 8;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_FRAMES   = 8'h08;
    localparam logic [7:0]  ADDR_DROPPED  = 8'h0C;
    localparam logic [1:0]  CTRL_RESET    = 2'h3;
    localparam int          CTRL_SMP_BIT  = 0;
    localparam int          CTRL_CMD_BIT  = 1;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    typedef enum logic [2:0] {
        CFR_IDLE, CFR_START, CFR_LEN_HI, CFR_LEN_LO, CFR_BODY, CFR_SUM
    } cfr_state_t;
endpackage : cfr_pkg

// >>> rtl/cfr_stream_if.sv
`timescale 1ns/10ps
// Purpose : Byte stream between framer and its output FIFO
// Assumes : Same clock on both sides
// Notes   : Item moves when valid and ready are both high
interface cfr_stream_if;
    logic [7:0] data;
    logic       valid;
    logic       ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : cfr_stream_if

// >>> rtl/cfr_fifo.sv
`timescale 1ns/10ps
// Purpose : Synchronous FIFO with registered read side
// Assumes : Single clock, synchronous active-high reset
// Notes   : Output stage is a flop so top outputs come from flops
module cfr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // Fill side
    cfr_stream_if.snk             wr,
    // Drain side
    output logic [WIDTH-1:0]      rd_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      cnt_reg;
    logic             do_wr;
    logic             do_rd;
    logic             out_load;

    // ************************************************************
    // Handshake decode
    // ************************************************************
    assign wr.ready = (cnt_reg != DEPTH[AW:0]);
    assign do_wr    = wr.valid && wr.ready;
    assign out_load = !rd_valid || rd_ready;
    assign do_rd    = out_load && (cnt_reg != '0);
    assign level    = cnt_reg;

    // Storage write
    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wptr_reg] <= wr.data;
        end
    end

    // Pointers, count and output stage
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else begin
            if (do_wr) wptr_reg <= wptr_reg + 1'b1;
            if (do_rd) rptr_reg <= rptr_reg + 1'b1;
            cnt_reg <= cnt_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
            if (out_load) rd_valid <= (cnt_reg != '0);
            if (do_rd) rd_data <= mem[rptr_reg];
        end
    end
endmodule : cfr_fifo

// >>> rtl/cfr_framer.sv
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
// Purpose : Builds 16-bit source sample frames and command responses
// Assumes : Single 25 MHz clock, synchronous active-high reset
// Notes   : Control and counters over AXI4-Lite; bytes leave via FIFO
module cfr_framer (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Sample request from receive path
    input  wire logic        smp_valid,
    output logic             smp_ready,
    input  wire logic [15:0] smp_src_addr,
    input  wire logic [7:0]  smp_rssi_mag,
    input  wire logic [7:0]  smp_options,
    input  wire logic [7:0]  smp_set_count,
    input  wire logic [15:0] smp_chan_mask,
    input  wire logic [8:0]  smp_digital,
    input  wire logic [39:0] smp_analog,
    // Command response request
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [7:0]  cmd_frame_id,
    input  wire logic [15:0] cmd_name,
    input  wire logic [7:0]  cmd_status,
    input  wire logic        cmd_is_query,
    input  wire logic        cmd_seq_end,
    input  wire logic [2:0]  cmd_data_len,
    input  wire logic [31:0] cmd_data,
    // Serial byte output
    output logic [7:0]       ser_data,
    output logic             ser_valid,
    input  wire logic        ser_ready,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    cfr_stream_if            st ();
    cfr_pkg::cfr_state_t     state_reg, state_next;
    logic [7:0]              frame_mem [0:cfr_pkg::FRAME_MAX-1];
    logic [7:0]              bld [0:cfr_pkg::FRAME_MAX-1];
    logic [4:0]              bld_len;
    logic [4:0]              len_reg;
    logic [4:0]              idx_reg;
    logic [7:0]              sum_reg;
    logic                    kind_cmd_reg;
    logic [7:0]              byte_reg;
    logic                    bvalid_reg;
    logic [1:0]              ctrl_reg;
    logic [31:0]             frames_reg;
    logic [31:0]             dropped_reg;
    logic [5:0]              fifo_level;
    logic                    take_cmd, take_smp, take_any, drop_cmd;
    logic                    out_free, load_byte;
    logic [7:0]              next_byte;

    // ************************************************************
    // Request acceptance
    // ************************************************************
    // Command responses win over samples; both wait for an idle framer
    assign take_cmd = cmd_valid && cmd_ready;
    assign take_smp = smp_valid && smp_ready && !take_cmd;
    assign take_any = take_cmd || take_smp;
    assign drop_cmd = take_cmd && (cmd_frame_id == 8'h00); // [R14]

    // Frame body assembly for whichever request is taken
    always_comb begin
        int n;
        n = 0;
        for (int i = 0; i < cfr_pkg::FRAME_MAX; i++) bld[i] = 8'h00;
        if (cmd_valid && cmd_ready) begin
            bld[0] = cfr_pkg::TYPE_CMD_RESP;                  // [R12]
            bld[1] = cmd_frame_id;                            // [R14]
            bld[2] = cmd_name[15:8];                          // [R15]
            bld[3] = cmd_name[7:0];                           // [R15]
            // Final frame of a multi-frame set is forced to a bare OK
            bld[4] = cmd_seq_end ? cfr_pkg::STATUS_OK
                                 : cmd_status;                // [R16] [R13]
            n = cfr_pkg::CMD_FIXED_LEN;
            if (cmd_is_query && !cmd_seq_end) begin           // [R17]
                for (int i = 0; i < cfr_pkg::CMD_DATA_MAX; i++) begin
                    if (i < int'(cmd_data_len)) begin
                        bld[n] = cmd_data[31-8*i -: 8];
                        n = n + 1;
                    end
                end
            end
        end else begin
            bld[0] = cfr_pkg::TYPE_SAMPLE16;                  // [R1]
            bld[1] = smp_src_addr[15:8];                      // [R2]
            bld[2] = smp_src_addr[7:0];                       // [R2]
            bld[3] = smp_rssi_mag;                            // [R3]
            bld[4] = smp_options & cfr_pkg::OPT_KEEP_MASK;    // [R4]
            bld[5] = smp_set_count;                           // [R5]
            // Reserved mask bits are never passed through
            bld[6] = {3'b000, smp_chan_mask[12:8]};           // [R6] [R7]
            bld[7] = smp_chan_mask[7:0];                      // [R6]
            n = cfr_pkg::SMP_FIXED_LEN;
            if (smp_chan_mask[8:0] != 9'h000) begin           // [R8] [R9]
                bld[n]   = {7'h00, smp_digital[8] & smp_chan_mask[8]};
                bld[n+1] = smp_digital[7:0] & smp_chan_mask[7:0];
                n = n + 2;
            end
            for (int c = 0; c < cfr_pkg::ANA_CHANNELS; c++) begin // [R11]
                if (smp_chan_mask[cfr_pkg::MASK_ANA_LSB + c]) begin
                    bld[n]   = {6'h00, smp_analog[10*c+8 +: 2]};  // [R10]
                    bld[n+1] = smp_analog[10*c +: 8];
                    n = n + 2;
                end
            end
        end
        bld_len = 5'(n);
    end

    // ************************************************************
    // Envelope sequencer
    // ************************************************************
    assign out_free  = !bvalid_reg || st.ready;
    assign load_byte = out_free && (state_reg != cfr_pkg::CFR_IDLE);

    // Byte to emit in the current state
    always_comb begin
        unique case (state_reg)
            cfr_pkg::CFR_START:  next_byte = cfr_pkg::START_DELIM; // [R18]
            cfr_pkg::CFR_LEN_HI: next_byte = 8'h00;
            cfr_pkg::CFR_LEN_LO: next_byte = {3'b000, len_reg};
            cfr_pkg::CFR_BODY:   next_byte = frame_mem[idx_reg];
            cfr_pkg::CFR_SUM:    next_byte = cfr_pkg::CSUM_BASE - sum_reg;
            default:             next_byte = 8'h00;
        endcase
    end

    // Next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            cfr_pkg::CFR_IDLE:
                if (take_any && !drop_cmd) state_next = cfr_pkg::CFR_START;
            cfr_pkg::CFR_START:
                if (out_free) state_next = cfr_pkg::CFR_LEN_HI;
            cfr_pkg::CFR_LEN_HI:
                if (out_free) state_next = cfr_pkg::CFR_LEN_LO;
            cfr_pkg::CFR_LEN_LO:
                if (out_free) state_next = cfr_pkg::CFR_BODY;
            cfr_pkg::CFR_BODY:
                if (out_free && idx_reg == len_reg - 5'd1)
                    state_next = cfr_pkg::CFR_SUM;
            cfr_pkg::CFR_SUM:
                if (out_free) state_next = cfr_pkg::CFR_IDLE;
            default: state_next = cfr_pkg::CFR_IDLE;
        endcase
    end

    // Capture the assembled frame at acceptance
    always_ff @(posedge core_clk) begin
        if (take_any) begin
            for (int i = 0; i < cfr_pkg::FRAME_MAX; i++) frame_mem[i] <= bld[i];
        end
    end

    // Sequencer registers; ready flags are flops set on return to idle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg    <= cfr_pkg::CFR_IDLE;
            len_reg      <= '0;
            idx_reg      <= '0;
            sum_reg      <= '0;
            kind_cmd_reg <= 1'b0;
            smp_ready    <= 1'b0;
            cmd_ready    <= 1'b0;
        end else begin
            state_reg <= state_next;
            smp_ready <= (state_next == cfr_pkg::CFR_IDLE) && !take_any
                         && ctrl_reg[cfr_pkg::CTRL_SMP_BIT];
            cmd_ready <= (state_next == cfr_pkg::CFR_IDLE) && !take_any
                         && ctrl_reg[cfr_pkg::CTRL_CMD_BIT];
            if (take_any) begin
                len_reg      <= bld_len;
                idx_reg      <= '0;
                sum_reg      <= '0;
                kind_cmd_reg <= take_cmd;
            end else if (load_byte && state_reg == cfr_pkg::CFR_BODY) begin
                idx_reg <= idx_reg + 5'd1;
                sum_reg <= sum_reg + next_byte;   // [R18]
            end
        end
    end

    // Output stage toward the FIFO
    always_ff @(posedge core_clk) begin
        if (srst) begin
            bvalid_reg <= 1'b0;
            byte_reg   <= 8'h00;
        end else if (out_free) begin
            bvalid_reg <= load_byte;
            byte_reg   <= next_byte;
        end
    end

    assign st.data  = byte_reg;
    assign st.valid = bvalid_reg;

    // Deep buffer lets a whole frame leave while the host UART lags
    cfr_fifo #(
        .WIDTH (cfr_pkg::FIFO_WIDTH),
        .DEPTH (cfr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .srst     (srst),
        .wr       (st),
        .rd_data  (ser_data),
        .rd_valid (ser_valid),
        .rd_ready (ser_ready),
        .level    (fifo_level)
    );

    // ************************************************************
    // AXI4-Lite register slave
    // ************************************************************
    logic [7:0]  aw_addr_reg;
    logic        aw_have_reg, w_have_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        wr_fire;
    logic [31:0] rd_word;
    logic        rd_hit;

    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

    // Read decode; unmapped addresses answer SLVERR with zero data
    assign rd_hit  = (s_axi_araddr == cfr_pkg::ADDR_CTRL)
                  || (s_axi_araddr == cfr_pkg::ADDR_STATUS)
                  || (s_axi_araddr == cfr_pkg::ADDR_FRAMES)
                  || (s_axi_araddr == cfr_pkg::ADDR_DROPPED);
    assign rd_word =
        (s_axi_araddr == cfr_pkg::ADDR_CTRL)    ? {30'h0, ctrl_reg} :
        (s_axi_araddr == cfr_pkg::ADDR_STATUS)  ?
            {24'h0, 1'b0, fifo_level, state_reg != cfr_pkg::CFR_IDLE} :
        (s_axi_araddr == cfr_pkg::ADDR_FRAMES)  ? frames_reg :
        (s_axi_araddr == cfr_pkg::ADDR_DROPPED) ? dropped_reg : 32'h0;

    // Write channel: address and data taken in either order
    always_ff @(posedge core_clk) begin
        if (srst) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= cfr_pkg::RESP_OKAY;
            ctrl_reg      <= cfr_pkg::CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_reg == cfr_pkg::ADDR_CTRL) begin
                    s_axi_bresp <= cfr_pkg::RESP_OKAY;
                    if (w_strb_reg[0]) ctrl_reg <= w_data_reg[1:0];
                end else begin
                    s_axi_bresp <= cfr_pkg::RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= cfr_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? cfr_pkg::RESP_OKAY
                                    : cfr_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Frame and drop counters; counters wrap silently
    always_ff @(posedge core_clk) begin
        if (srst) begin
            frames_reg  <= 32'h0;
            dropped_reg <= 32'h0;
        end else begin
            if (load_byte && state_reg == cfr_pkg::CFR_SUM)
                frames_reg <= frames_reg + 32'h1;
            if (drop_cmd) dropped_reg <= dropped_reg + 32'h1;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_delim;
        @(posedge core_clk) disable iff (srst)
        (state_reg == cfr_pkg::CFR_START && out_free)
            |=> (bvalid_reg && byte_reg == 8'h7E);
    endproperty
    a_delim: assert property (p_delim) // [R18]
        else $error("start delimiter missing");

    property p_type;
        @(posedge core_clk) disable iff (srst)
        (state_reg == cfr_pkg::CFR_BODY && idx_reg == 5'd0 && out_free)
            |=> byte_reg == (kind_cmd_reg ? 8'h88 : 8'h83);
    endproperty
    a_type: assert property (p_type) // [R1] [R12]
        else $error("wrong frame type byte");

    property p_drop_zero;
        @(posedge core_clk) disable iff (srst)
        drop_cmd |=> (state_reg == cfr_pkg::CFR_IDLE) [*2];
    endproperty
    a_drop_zero: assert property (p_drop_zero) // [R14]
        else $error("frame sent for id zero");

    property p_seq_end;
        @(posedge core_clk) disable iff (srst)
        (take_cmd && !drop_cmd && cmd_seq_end)
            |=> (len_reg == 5'd5 && frame_mem[4] == 8'h00);
    endproperty
    a_seq_end: assert property (p_seq_end) // [R13]
        else $error("sequence end carries data or error");

    property p_addr;
        @(posedge core_clk) disable iff (srst)
        take_smp |=> (frame_mem[1] == $past(smp_src_addr[15:8])
                      && frame_mem[2] == $past(smp_src_addr[7:0]));
    endproperty
    a_addr: assert property (p_addr) // [R2]
        else $error("source address misplaced");

    property p_opts;
        @(posedge core_clk) disable iff (srst)
        take_smp |=> (frame_mem[4][7:3] == 5'h00 && !frame_mem[4][0]
                      && frame_mem[3] == $past(smp_rssi_mag));
    endproperty
    a_opts: assert property (p_opts) // [R3] [R4]
        else $error("options or strength wrong");

    property p_no_dig;
        @(posedge core_clk) disable iff (srst)
        (take_smp && smp_chan_mask[8:0] == 9'h000 && smp_chan_mask[9])
            |=> frame_mem[8] == {6'h00, $past(smp_analog[9:8])};
    endproperty
    a_no_dig: assert property (p_no_dig) // [R9] [R10]
        else $error("analog does not follow mask");

    property p_write_len;
        @(posedge core_clk) disable iff (srst)
        (take_cmd && !cmd_is_query) |=> len_reg == 5'd5;
    endproperty
    a_write_len: assert property (p_write_len) // [R17]
        else $error("write response carries data");

    property p_sum;
        @(posedge core_clk) disable iff (srst)
        (state_reg == cfr_pkg::CFR_SUM && out_free)
            |=> byte_reg + $past(sum_reg) == 8'hFF;
    endproperty
    a_sum: assert property (p_sum) // [R18]
        else $error("checksum wrong");
endmodule : cfr_framer

// >>> verification/cfr_host_model.sv
`timescale 1ns/10ps
// Purpose : Host that reads frame bytes off the serial side
// Assumes : Bytes move when valid and ready are both high
// Notes   : Stalls one cycle in four so the FIFO backs up
module cfr_host_model (
    // Clock
    input  wire logic       core_clk,
    // Serial byte stream
    input  wire logic [7:0] ser_data,
    input  wire logic       ser_valid,
    output logic            ser_ready
);
    logic [7:0] rx_q[$];
    logic [1:0] stall_cnt = 2'h0;
    initial ser_ready = 1'b0;
    // Capture taken bytes; ready follows a fixed stall pattern
    always @(posedge core_clk) begin
        if (ser_valid && ser_ready)
            rx_q.push_back(ser_data);
        stall_cnt <= stall_cnt + 2'h1;
        ser_ready <= (stall_cnt != 2'h3);
    end
endmodule : cfr_host_model

// >>> verification/cfr_framer_tb_top.sv
`timescale 1ns/10ps
// Purpose : Self-checking bench for the frame builder
// Assumes : Host model drains serial bytes with stalls
// Notes   : Frames compared byte by byte, envelope included
module cfr_framer_tb_top;
    logic core_clk = 0, srst = 1, smp_valid = 0, cmd_valid = 0;
    logic cmd_is_query = 0, cmd_seq_end = 0, s_axi_awvalid = 0;
    logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, smp_ready, cmd_ready, ser_valid, ser_ready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [2:0]  cmd_data_len = '0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [7:0]  smp_rssi_mag = '0, smp_options = '0, smp_set_count = '0;
    logic [7:0]  cmd_frame_id = '0, cmd_status = '0, ser_data;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [8:0]  smp_digital = '0;
    logic [15:0] smp_src_addr = '0, smp_chan_mask = '0, cmd_name = '0;
    logic [31:0] cmd_data = '0, s_axi_wdata = '0, s_axi_rdata, rd;
    logic [39:0] smp_analog = '0;
    int          mismatches = 0, samples_checked = 0;
    always #20 core_clk = ~core_clk;
    cfr_framer     i_dut (.*);
    cfr_host_model i_host (.core_clk(core_clk), .ser_data(ser_data),
                           .ser_valid(ser_valid), .ser_ready(ser_ready));
    task automatic chk(input string n, input logic [31:0] e, s);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Envelope built here; wait is bounded so a lost frame shows
    task automatic expect_frame(input string n, input logic [7:0] d[$]);
        logic [7:0] e[$];
        logic [7:0] sum;
        int k;
        sum = 8'hFF;
        foreach (d[i]) sum -= d[i];
        e = {8'h7E, 8'h00, 8'(d.size()), d, sum};
        k = 0;
        while (i_host.rx_q.size() < e.size() && k < 500) begin
            @(posedge core_clk);
            k++;
        end
        chk(n, e.size(), i_host.rx_q.size());
        foreach (e[i]) chk(n, e[i], i_host.rx_q.pop_front());
    endtask : expect_frame
    // Ready is a flop, so its negedge value is what the edge sees
    task automatic raise(input bit cmd);
        if (cmd) cmd_valid <= 1'b1;
        else smp_valid <= 1'b1;
        @(negedge core_clk);
        while ((cmd ? cmd_ready : smp_ready) !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        smp_valid <= 1'b0;
    endtask : raise
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (b !== 1'b1);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        logic ar, r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            ar = s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            if (ar) s_axi_arvalid <= 1'b0;
        end while (r !== 1'b1);
    endtask : axi_rd
    // Reserved mask and option bits set to see them cleared
    task automatic smp_full();
        smp_src_addr <= 16'hA1B2;
        smp_rssi_mag <= 8'h28;
        smp_options <= 8'hFF;
        smp_set_count <= 8'h01;
        smp_chan_mask <= 16'hF503;
        smp_digital <= 9'h1FF;
        smp_analog <= {10'h001, 10'h155, 10'h2AB, 10'h3FF};
        raise(1'b0);
        expect_frame("smp_full", '{8'h83, 8'hA1, 8'hB2, 8'h28, 8'h06, 8'h01,
            8'h15, 8'h03, 8'h01, 8'h03, 8'h02, 8'hAB, 8'h00, 8'h01});
    endtask : smp_full
    task automatic cmd_frames();
        cmd_frame_id <= 8'h01;
        cmd_name <= 16'h4244;
        cmd_is_query <= 1'b1;
        cmd_data_len <= 3'h2;
        cmd_data <= 32'hC0DE_5A5A;
        raise(1'b1);
        expect_frame("cmd_query", '{8'h88, 8'h01, 8'h42, 8'h44, 8'h00,
            8'hC0, 8'hDE});
        // Every status code, each a write so no data bytes
        for (int s = 0; s < 4; s++) begin
            cmd_is_query <= 1'b0;
            cmd_status <= 8'(s);
            raise(1'b1);
            expect_frame("cmd_status", '{8'h88, 8'h01, 8'h42, 8'h44,
                8'(s)});
        end
        cmd_seq_end <= 1'b1;
        cmd_is_query <= 1'b1;
        cmd_name <= 16'h4E44;
        raise(1'b1);
        expect_frame("cmd_end", '{8'h88, 8'h01, 8'h4E, 8'h44, 8'h00});
        cmd_frame_id <= '0;
        raise(1'b1);
        repeat (60) @(posedge core_clk);
        chk("zero_id_bytes", '0, i_host.rx_q.size());
    endtask : cmd_frames
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        axi_rd(8'h00);
        chk("ctrl_reset", 32'h0000_0003, rd);
        axi_rd(8'h10);
        chk("unmapped_resp", 2'h2, resp);
        smp_full();
        smp_chan_mask <= 16'h0200;
        smp_options <= 8'h02;
        raise(1'b0);
        expect_frame("smp_nodig", '{8'h83, 8'hA1, 8'hB2, 8'h28, 8'h02,
            8'h01, 8'h02, 8'h00, 8'h03, 8'hFF});
        cmd_frames();
        axi_wr(8'h08, 32'h0000_0001);
        chk("ro_write_resp", 2'h2, resp);
        axi_rd(8'h0C);
        chk("dropped", 32'h0000_0001, rd);
        axi_rd(8'h08);
        chk("frames", 32'h0000_0008, rd);
        // Sample path gated off: request must wait untaken
        axi_wr(8'h00, 32'h0000_0002);
        smp_valid <= 1'b1;
        repeat (20) @(negedge core_clk) chk("gated", '0, smp_ready);
        @(posedge core_clk);
        axi_wr(8'h00, 32'h0000_0001);
        cmd_valid <= 1'b1;
        smp_full();
        wrap_up();
    end
endmodule : cfr_framer_tb_top
